// file: shared/sbrg_map.vh
`ifndef SBRG_MAP_VH
`define SBRG_MAP_VH

// ****************************************
// Register addresses (byte index)
// ****************************************
`define SBRG_ADDR_W 3
`define SBRG_OFF_BAUD_CONTROL 3'h0
`define SBRG_OFF_RX_STATUS 3'h1
`define SBRG_OFF_DIV_LOW 3'h2
`define SBRG_OFF_DIV_HIGH 3'h3
`define SBRG_OFF_TX_STATUS 3'h4

// ****************************************
// Field positions
// ****************************************
`define SBRG_BAUD_RX_IDLE_BIT 6
`define SBRG_BAUD_WIDE_BIT 3
`define SBRG_BAUD_WRITE_MASK 8'h9B
`define SBRG_TX_SYNC_BIT 4
`define SBRG_TX_HIGH_SPEED_BIT 2
`define SBRG_TX_WRITE_MASK 8'hFD
`define SBRG_TX_SHIFT_EMPTY_BIT 1

// ****************************************
// Reset values
// ****************************************
`define SBRG_RST_BAUD_CONTROL 8'h00
`define SBRG_RST_RX_STATUS 8'h00
`define SBRG_RST_DIV 8'h00
`define SBRG_RST_TX_STATUS 8'h00

// ****************************************
// Clock multipliers as prescale counts
// ****************************************
`define SBRG_PRE_W 6
`define SBRG_PRE_64 6'h3F
`define SBRG_PRE_16 6'h0F
`define SBRG_PRE_4 6'h03

`endif

// file: verilog/sbrg_down_counter.v
`timescale 1ns/1ps
`include "sbrg_map.vh"

// Reloading down counter: pulses tick for one cycle when it passes zero
module sbrg_down_counter #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Control
	input wire clear,
	input wire enable,
	input wire [WIDTH-1:0] reload,
	// Result
	output wire tick
);
	reg [WIDTH-1:0] count_reg;
	reg [WIDTH-1:0] count_next;

	assign tick = enable && !clear && (count_reg == {WIDTH{1'b0}});

	always @* begin
		count_next = count_reg;
		if (clear) begin
			count_next = reload;
		end else if (enable) begin
			if (count_reg == {WIDTH{1'b0}}) begin
				count_next = reload;
			end else begin
				count_next = count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			count_reg <= {WIDTH{1'b0}};
		end else begin
			count_reg <= count_next;
		end
	end
endmodule

// file: verilog/sbrg_rate_timer.v
`timescale 1ns/1ps
`include "sbrg_map.vh"

// Notes on behaviour
// - One rate timer serves both asynchronous and synchronous operation.
// - After reset the timer uses only the low divisor byte (8-bit mode).
// - Wide-counter select set uses the full 16-bit divisor.
// - Timer runs continuously; its period comes from the divisor bytes.
// - Divisor n is high byte (15:8) joined with low byte (7:0).
// - Asynchronous multiplier depends on high-speed and wide-counter selects.
// - Synchronous mode ignores high-speed select.
// - Async, 8-bit, high-speed clear: tick rate is clock / (64*(n+1)).
// - Async, 16-bit, high-speed clear: tick rate is clock / (16*(n+1)).
// - Synchronous: tick rate is clock / (4*(n+1)).
// - Any divisor write clears the timer at once.
module sbrg_rate_timer #(
	parameter DIV_WIDTH = 16
) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Register port
	input wire [`SBRG_ADDR_W-1:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrStrobe,
	input wire regRdStrobe,
	output reg [7:0] regRdData,
	// Status from the shift logic
	input wire receiverIdleFlag,
	input wire shiftEmpty,
	// Rate outputs to the shift logic
	output wire rateTick,
	output wire syncMode,
	output wire wideCounterSelect,
	output wire highSpeedSelect
);
	// ****************************************
	// Registers
	// ****************************************
	reg [7:0] baudControl_reg;
	reg [7:0] baudControl_next;
	reg [7:0] rxStatus_reg;
	reg [7:0] rxStatus_next;
	reg [7:0] divLow_reg;
	reg [7:0] divLow_next;
	reg [7:0] divHigh_reg;
	reg [7:0] divHigh_next;
	reg [7:0] txStatus_reg;
	reg [7:0] txStatus_next;
	reg [7:0] regRdData_next;
	reg wrBaud;
	reg wrRx;
	reg wrLow;
	reg wrHigh;
	reg wrTx;

	// ****************************************
	// Write decode
	// ****************************************
	// Unmapped indices decode to nothing, so stray writes are dropped
	always @* begin
		wrBaud = 1'b0;
		wrRx = 1'b0;
		wrLow = 1'b0;
		wrHigh = 1'b0;
		wrTx = 1'b0;
		if (regWrStrobe) begin
			case (regAddr)
				`SBRG_OFF_BAUD_CONTROL: begin
					wrBaud = 1'b1;
				end
				`SBRG_OFF_RX_STATUS: begin
					wrRx = 1'b1;
				end
				`SBRG_OFF_DIV_LOW: begin
					wrLow = 1'b1;
				end
				`SBRG_OFF_DIV_HIGH: begin
					wrHigh = 1'b1;
				end
				`SBRG_OFF_TX_STATUS: begin
					wrTx = 1'b1;
				end
				default: begin
					wrBaud = 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Register next values
	// ****************************************
	// The timer reloads from these, so a write counts from its own edge
	always @* begin
		baudControl_next = baudControl_reg;
		if (wrBaud) begin
			baudControl_next = regWrData & `SBRG_BAUD_WRITE_MASK;
		end
	end

	always @* begin
		rxStatus_next = rxStatus_reg;
		if (wrRx) begin
			rxStatus_next = regWrData;
		end
	end

	always @* begin
		divLow_next = divLow_reg;
		if (wrLow) begin
			divLow_next = regWrData;
		end
	end

	always @* begin
		divHigh_next = divHigh_reg;
		if (wrHigh) begin
			divHigh_next = regWrData;
		end
	end

	always @* begin
		txStatus_next = txStatus_reg;
		if (wrTx) begin
			txStatus_next = regWrData & `SBRG_TX_WRITE_MASK;
		end
	end

	// ****************************************
	// Register storage
	// ****************************************
	// Reset lands in 8-bit asynchronous mode with a zero divisor
	always @(posedge mclk) begin
		if (rst) begin
			baudControl_reg <= `SBRG_RST_BAUD_CONTROL;
		end else begin
			baudControl_reg <= baudControl_next;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			rxStatus_reg <= `SBRG_RST_RX_STATUS;
		end else begin
			rxStatus_reg <= rxStatus_next;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			divLow_reg <= `SBRG_RST_DIV;
		end else begin
			divLow_reg <= divLow_next;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			divHigh_reg <= `SBRG_RST_DIV;
		end else begin
			divHigh_reg <= divHigh_next;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			txStatus_reg <= `SBRG_RST_TX_STATUS;
		end else begin
			txStatus_reg <= txStatus_next;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// Status bits are live inputs; stored copies of them would go stale
	always @* begin
		regRdData_next = 8'h00;
		case (regAddr)
			`SBRG_OFF_BAUD_CONTROL: begin
				regRdData_next = baudControl_reg;
				regRdData_next[`SBRG_BAUD_RX_IDLE_BIT] = receiverIdleFlag;
			end
			`SBRG_OFF_RX_STATUS: begin
				regRdData_next = rxStatus_reg;
			end
			`SBRG_OFF_DIV_LOW: begin
				regRdData_next = divLow_reg;
			end
			`SBRG_OFF_DIV_HIGH: begin
				regRdData_next = divHigh_reg;
			end
			`SBRG_OFF_TX_STATUS: begin
				regRdData_next = txStatus_reg;
				regRdData_next[`SBRG_TX_SHIFT_EMPTY_BIT] = shiftEmpty;
			end
			default: begin
				regRdData_next = 8'h00;
			end
		endcase
	end

	always @(posedge mclk) begin
		if (rst) begin
			regRdData <= 8'h00;
		end else if (regRdStrobe) begin
			regRdData <= regRdData_next;
		end else begin
			regRdData <= 8'h00;
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	assign wideCounterSelect = baudControl_reg[`SBRG_BAUD_WIDE_BIT];
	assign highSpeedSelect = txStatus_reg[`SBRG_TX_HIGH_SPEED_BIT];
	assign syncMode = txStatus_reg[`SBRG_TX_SYNC_BIT];

	// ****************************************
	// Rate select
	// ****************************************
	// Next-cycle mode bits, so a mode write reloads with its own settings
	wire nextWide = baudControl_next[`SBRG_BAUD_WIDE_BIT];
	wire nextHighSpeed = txStatus_next[`SBRG_TX_HIGH_SPEED_BIT];
	wire nextSync = txStatus_next[`SBRG_TX_SYNC_BIT];

	// Narrow mode ignores the high byte, which stays readable
	wire [15:0] divisorFull = {divHigh_next, divLow_next};
	wire [DIV_WIDTH-1:0] divisor = nextWide ? divisorFull[DIV_WIDTH-1:0]
		: {{(DIV_WIDTH-8){1'b0}}, divLow_next};

	reg [`SBRG_PRE_W-1:0] preReload;

	// Multiplier of one bit period, minus one
	always @* begin
		preReload = `SBRG_PRE_64;
		case ({nextSync, nextWide, nextHighSpeed})
			3'b000: begin
				preReload = `SBRG_PRE_64;
			end
			3'b001: begin
				preReload = `SBRG_PRE_16;
			end
			3'b010: begin
				preReload = `SBRG_PRE_16;
			end
			3'b011: begin
				preReload = `SBRG_PRE_4;
			end
			3'b100: begin
				preReload = `SBRG_PRE_4;
			end
			3'b101: begin
				preReload = `SBRG_PRE_4;
			end
			3'b110: begin
				preReload = `SBRG_PRE_4;
			end
			3'b111: begin
				preReload = `SBRG_PRE_4;
			end
			default: begin
				preReload = `SBRG_PRE_64;
			end
		endcase
	end

	// ****************************************
	// Timer chain
	// ****************************************
	// One timer for both modes, free running; any divisor write restarts it
	wire divWrite = wrLow || wrHigh;
	// A mode change also restarts the chain so no stale long count lingers
	wire modeWrite = wrBaud || wrTx;
	// Restart loads on the write edge itself, from the values being written;
	// the first tick then follows that edge by one full bit period
	wire restart = divWrite || modeWrite;
	wire preTick;

	sbrg_down_counter #(
		.WIDTH(`SBRG_PRE_W)
	) prescaler (
		.mclk(mclk),
		.rst(rst),
		.clear(restart),
		.enable(1'b1),
		.reload(preReload),
		.tick(preTick)
	);

	sbrg_down_counter #(
		.WIDTH(DIV_WIDTH)
	) divider (
		.mclk(mclk),
		.rst(rst),
		.clear(restart),
		.enable(preTick),
		.reload(divisor),
		.tick(rateTick)
	);
endmodule

// file: test/sbrg_rate_timer_assertions.sv
`timescale 1ns/1ps
`include "sbrg_map.vh"
module sbrg_rate_timer_checker (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Register port
	input wire [`SBRG_ADDR_W-1:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrStrobe,
	input wire regRdStrobe,
	input wire [7:0] regRdData,
	// Rate outputs
	input wire rateTick,
	input wire syncMode,
	input wire wideCounterSelect,
	input wire highSpeedSelect
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_read_idle_zero: assert property (!$past(regRdStrobe) |-> regRdData == 8'h00) else $error("read idle");
	a_wide_follows: assert property (regWrStrobe && regAddr == 3'h0 |=>
		wideCounterSelect == $past(regWrData[3])) else $error("wide select");
	a_sync_follows: assert property (regWrStrobe && regAddr == 3'h4 |=>
		syncMode == $past(regWrData[4])) else $error("sync select");
	a_speed_follows: assert property (regWrStrobe && regAddr == 3'h4 |=>
		highSpeedSelect == $past(regWrData[2])) else $error("speed select");
	a_div_clear: assert property (regWrStrobe && regAddr[2:1] == 2'h1 |=> !rateTick [*3])
		else $error("no clear");
	a_tick_pulse: assert property (rateTick |=> !rateTick) else $error("tick width");
	// Low byte 1 means n+1 = 2 in 8-bit mode
	a_sync_rate: assert property (regWrStrobe && regAddr == 3'h2 && regWrData == 8'h01 && syncMode
		&& !wideCounterSelect |-> ##8 rateTick) else $error("sync rate");
	a_slow_rate: assert property (regWrStrobe && regAddr == 3'h2 && regWrData == 8'h01 && !syncMode
		&& !wideCounterSelect && !highSpeedSelect |-> ##128 rateTick) else $error("slow rate");
	cover property (rateTick && syncMode && wideCounterSelect);
	cover property (rateTick && highSpeedSelect && !syncMode);
	cover property (regRdStrobe ##1 regRdData != 8'h00);
endmodule
bind sbrg_rate_timer sbrg_rate_timer_checker sbrg_rate_timer_checker_inst (.mclk, .rst, .regAddr, .regWrData,
	.regWrStrobe, .regRdStrobe, .regRdData, .rateTick, .syncMode, .wideCounterSelect, .highSpeedSelect);

// file: test/sbrg_shift_model.sv
`timescale 1ns/1ps
// Shift logic stand-in: idle and empty unless a reception is in flight
module sbrg_shift_model (
	// Test control
	input wire rxBusy,
	// Status to the rate timer
	output wire receiverIdleFlag,
	output wire shiftEmpty
);
	assign receiverIdleFlag = !rxBusy;
	assign shiftEmpty = !rxBusy;
endmodule

// file: test/sbrg_rate_timer_tb_top.sv
`timescale 1ns/1ps
module sbrg_rate_timer_tb_top;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg [2:0] regAddr = 3'h0;
	reg [7:0] regWrData = 8'h00;
	reg regWrStrobe = 1'b0;
	reg regRdStrobe = 1'b0;
	reg rxBusy = 1'b0;
	wire [7:0] regRdData;
	wire receiverIdleFlag, shiftEmpty, rateTick, syncMode, wideCounterSelect, highSpeedSelect;
	integer errCount = 0;
	integer nCompared = 0;
	integer i, m, n;
	always #2.5 mclk = ~mclk;
	sbrg_shift_model sbrg_shift_model_inst (.rxBusy, .receiverIdleFlag, .shiftEmpty);
	sbrg_rate_timer sbrg_rate_timer_inst (.mclk, .rst, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe,
		.regRdData, .receiverIdleFlag, .shiftEmpty, .rateTick, .syncMode, .wideCounterSelect, .highSpeedSelect);
	task finalReport;
		begin
			$display("Compared %0d, mismatches %0d", nCompared, errCount);
			if (errCount == 0 && nCompared > 0) begin
				$display("Simulation passed");
			end else begin
				$display("Simulation failed");
			end
			$finish;
		end
	endtask
	task cmp(input string what, input [31:0] exp, input [31:0] got);
		begin
			nCompared++;
			if (got !== exp) begin
				$display("ERROR %s expected %0h seen %0h", what, exp, got);
				errCount++;
			end
		end
	endtask
	task wr(input [2:0] a, input [7:0] d);
		begin
			@(posedge mclk);
			regAddr <= a;
			regWrData <= d;
			regWrStrobe <= 1'b1;
			@(posedge mclk);
			regWrStrobe <= 1'b0;
		end
	endtask
	task rd(input [2:0] a, input [7:0] e);
		begin
			@(posedge mclk);
			regAddr <= a;
			regRdStrobe <= 1'b1;
			@(posedge mclk);
			regRdStrobe <= 1'b0;
			#1 cmp("read", {24'h0, e}, {24'h0, regRdData});
		end
	endtask
	// Counts edges up to the one that samples the tick; bounded so a dead timer ends the run
	task meas(input integer e);
		integer c;
		begin
			#1;
			for (c = 1; c < 9000 && rateTick !== 1'b1; c++) @(posedge mclk) #1;
			cmp("period", e, c);
			if (c == 9000) finalReport;
		end
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		for (i = 0; i < 8; i++) rd(i[2:0], (i == 0) ? 8'h40 : (i == 4) ? 8'h02 : 8'h00);
		wr(3'h0, 8'hFF);
		rxBusy <= 1'b1;
		rd(3'h0, 8'h9B);
		wr(3'h4, 8'hFF);
		rd(3'h4, 8'hFD);
		// Every sync, wide and speed combination; high byte 1 shows the high byte counts only in wide mode
		for (i = 0; i < 8; i++) begin
			wr(3'h4, {3'h0, i[2], 1'h0, i[1], 2'h0});
			wr(3'h0, {4'h0, i[0], 3'h0});
			wr(3'h3, 8'h01);
			wr(3'h2, 8'h01);
			m = i[2] ? 4 : (i[0] ? (i[1] ? 4 : 16) : (i[1] ? 16 : 64));
			n = i[0] ? 258 : 2;
			meas(m * n);
			@(posedge mclk);
			meas(m * n);
		end
		rd(3'h2, 8'h01);
		rd(3'h3, 8'h01);
		finalReport;
	end
endmodule
